// ==== epd_image_load_cmd_decoder.sv ====
// image-load command decoder: serial link capture, word fifo, decoder, line timer
// assumes link pins belong to link_clk, sensor and memory ports to core_clk
`timescale 1ns/10ps
`default_nettype none
module epd_image_load_cmd_decoder #(
  parameter int FIFO_DEPTH = epd_cmd_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // serial command link
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic link_dc,
  input wire logic link_mosi,
  output logic link_miso,
  output logic link_miso_oe,
  // configuration inputs
  input wire logic data_polarity_bit,
  input wire logic black_white_mode,
  // temperature sensors
  input wire logic [7:0] internal_temp_value,
  input wire logic [10:0] ext_temp_value,
  // pixel memory write port
  output logic mem_we,
  output logic mem_new_frame,
  output logic [7:0] mem_x,
  output logic [9:0] mem_y,
  output logic [7:0] mem_colour,
  output logic [7:0] mem_mask,
  output logic [7:0] mem_undef,
  input wire logic mem_ready,
  // settings and status
  output logic [7:0] win_x,
  output logic [9:0] win_y,
  output logic [7:0] win_w,
  output logic [9:0] win_l,
  output logic [7:0] line_period_count,
  output logic line_tick,
  output logic sensor_select_bit,
  output logic [3:0] temp_offset_field,
  output logic rx_ready,
  output logic rx_overflow,
  input wire logic clear_overflow
);
  // ****************************************
  // link domain: byte capture and read-back
  // ****************************************
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] shreg, next_shreg;
  logic [8:0] hold_word, next_hold_word;
  logic rx_tog, next_rx_tog;
  logic [1:0] slot, next_slot;
  logic read_mode, next_read_mode;
  logic [7:0] out_byte, next_out_byte;
  logic miso_en, next_miso_en;
  logic [15:0] shadow, next_shadow;
  logic ack_tog, next_ack_tog;
  logic req_l1, req_l2;
  logic req_tog, next_req_tog;
  logic [15:0] resp_hold;
  logic [7:0] done_byte;

  assign done_byte = {shreg, link_mosi};

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_hold_word = hold_word;
    next_rx_tog = rx_tog;
    next_slot = slot;
    next_read_mode = read_mode;
    next_out_byte = out_byte;
    next_miso_en = miso_en;
    next_shadow = shadow;
    next_ack_tog = ack_tog;
    if (req_l2 != ack_tog) begin
      next_shadow = resp_hold;
      next_ack_tog = ~ack_tog;
    end
    if (link_cs_n) begin
      next_bit_cnt = 3'h0;
      next_miso_en = 1'b0;
    end else begin
      next_shreg = done_byte[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_hold_word = {link_dc, done_byte};
        next_rx_tog = ~rx_tog;
        next_out_byte = 8'h00;
        next_miso_en = 1'b0;
        if (!link_dc) begin
          next_slot = 2'h0;
          next_read_mode = (done_byte == epd_cmd_pkg::CMD_TEMP_READ);
          if (done_byte == epd_cmd_pkg::CMD_TEMP_READ) begin
            next_out_byte = shadow[15:8]; // RULE11 RULE12
            next_miso_en = 1'b1;
          end
        end else begin
          if (slot != 2'h3) begin
            next_slot = slot + 2'h1;
          end
          if (read_mode && slot == 2'h0) begin
            next_out_byte = shadow[7:0]; // RULE12
            next_miso_en = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
      hold_word <= 9'h000;
      rx_tog <= 1'b0;
      slot <= 2'h0;
      read_mode <= 1'b0;
      out_byte <= 8'h00;
      miso_en <= 1'b0;
      shadow <= 16'h0000;
      ack_tog <= 1'b0;
      req_l1 <= 1'b0;
      req_l2 <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      hold_word <= next_hold_word;
      rx_tog <= next_rx_tog;
      slot <= next_slot;
      read_mode <= next_read_mode;
      out_byte <= next_out_byte;
      miso_en <= next_miso_en;
      shadow <= next_shadow;
      ack_tog <= next_ack_tog;
      req_l1 <= req_tog;
      req_l2 <= req_l1;
    end
  end

  // msb first; gated by the pin so the driver lets go when the frame ends
  assign link_miso = out_byte[~bit_cnt];
  assign link_miso_oe = miso_en & ~link_cs_n;

  // ****************************************
  // core domain: crossing and fifo
  // ****************************************
  logic rx_s1, rx_s2, rx_s3, ack_s1, ack_s2;
  logic [15:0] next_resp_hold;
  byte_stream_if #(.WIDTH(epd_cmd_pkg::LINK_WORD_W)) in_if ();
  byte_stream_if #(.WIDTH(epd_cmd_pkg::LINK_WORD_W)) out_if ();

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      rx_s3 <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      rx_s1 <= rx_tog;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
    end
  end

  // hold_word is stable for a whole byte time after its toggle
  assign in_if.valid = rx_s2 ^ rx_s3;
  assign in_if.data = hold_word;
  assign rx_ready = in_if.ready;
  assign out_if.ready = ~mem_we | mem_ready;

  link_word_fifo #(.WIDTH(epd_cmd_pkg::LINK_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr(in_if),
    .rd(out_if)
  );

  // ****************************************
  // decoder
  // ****************************************
  epd_cmd_pkg::dec_state_t state, next_state;
  logic [2:0] idx, next_idx;
  logic [7:0] pos_x, next_pos_x;
  logic [9:0] pos_y, next_pos_y;
  logic [7:0] next_win_x, next_win_w, next_line_period_count;
  logic [9:0] next_win_y, next_win_l;
  logic next_mem_we, next_mem_new_frame, next_sensor_select_bit, next_rx_overflow;
  logic [7:0] next_mem_x, next_mem_colour, next_mem_mask, next_mem_undef;
  logic [9:0] next_mem_y;
  logic [3:0] next_temp_offset_field, quad_colour, quad_undef, npix;
  logic pop, pop_dc, do_write;
  logic [7:0] pop_byte, int_adj;
  logic [8:0] x_end, x_step;
  logic [15:0] resp_now;

  assign pop = out_if.valid & out_if.ready;
  assign pop_dc = out_if.data[8];
  assign pop_byte = out_if.data[7:0];

  for (genvar i = 0; i < 4; i++) begin : g_quad
    wire logic [1:0] code = pop_byte[7-2*i -: 2]; // RULE3
    assign quad_colour[3-i] = data_polarity_bit ? (code == 2'b11) : (code == 2'b00); // RULE4
    assign quad_undef[3-i] = code[1] ^ code[0]; // RULE4
  end

  // offset steps are whole degrees, i.e. two half-degree counts
  assign int_adj = internal_temp_value + {{3{temp_offset_field[3]}}, temp_offset_field, 1'b0}; // RULE14
  assign resp_now = sensor_select_bit ? {ext_temp_value, 5'h00} : {int_adj, 8'h00}; // RULE11 RULE12
  assign npix = (state == epd_cmd_pkg::ST_MONO) ? epd_cmd_pkg::MONO_PIXELS
                                                : epd_cmd_pkg::QUAD_PIXELS;
  assign x_end = {1'b0, win_x} + {1'b0, win_w}; // RULE2
  assign x_step = {1'b0, pos_x} + {5'h00, npix};
  assign do_write = pop && pop_dc && (state == epd_cmd_pkg::ST_NEW ||
                    (state == epd_cmd_pkg::ST_MONO && black_white_mode)); // RULE7

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_pos_x = pos_x;
    next_pos_y = pos_y;
    next_win_x = win_x;
    next_win_y = win_y;
    next_win_w = win_w;
    next_win_l = win_l;
    next_line_period_count = line_period_count;
    next_sensor_select_bit = sensor_select_bit;
    next_temp_offset_field = temp_offset_field;
    next_mem_we = mem_we & ~mem_ready;
    next_mem_new_frame = mem_new_frame;
    next_mem_x = mem_x;
    next_mem_y = mem_y;
    next_mem_colour = mem_colour;
    next_mem_mask = mem_mask;
    next_mem_undef = mem_undef;
    next_rx_overflow = rx_overflow;
    next_req_tog = req_tog;
    next_resp_hold = resp_hold;
    if (clear_overflow) begin
      next_rx_overflow = 1'b0;
    end
    if (in_if.valid && !in_if.ready) begin
      next_rx_overflow = 1'b1;
    end
    if (ack_s2 == req_tog) begin
      next_resp_hold = resp_now;
      next_req_tog = ~req_tog;
    end
    if (pop && !pop_dc) begin // RULE15
      next_idx = 3'h0;
      next_pos_x = win_x;
      next_pos_y = win_y;
      unique case (pop_byte)
        epd_cmd_pkg::CMD_WINDOW: next_state = epd_cmd_pkg::ST_WINDOW;
        epd_cmd_pkg::CMD_NEW_LOAD: next_state = epd_cmd_pkg::ST_NEW;
        epd_cmd_pkg::CMD_MONO_OLD, epd_cmd_pkg::CMD_MONO_SECOND: next_state = epd_cmd_pkg::ST_MONO;
        epd_cmd_pkg::CMD_LINE_PERIOD: next_state = epd_cmd_pkg::ST_LINE;
        epd_cmd_pkg::CMD_SENSOR_SEL: next_state = epd_cmd_pkg::ST_SEL;
        default: next_state = epd_cmd_pkg::ST_SKIP;
      endcase
    end else if (pop) begin
      unique case (state)
        epd_cmd_pkg::ST_WINDOW: begin // RULE5
          unique case (idx)
            3'h0: next_win_x = pop_byte; // RULE1
            3'h1: next_win_y[9:8] = pop_byte[1:0]; // RULE1
            3'h2: next_win_y[7:0] = pop_byte;
            3'h3: next_win_w = pop_byte; // RULE2
            3'h4: next_win_l[9:8] = pop_byte[1:0]; // RULE2
            default: next_win_l[7:0] = pop_byte;
          endcase
          next_idx = idx + 3'h1;
          if (idx == epd_cmd_pkg::WIN_LAST_IDX) begin
            next_state = epd_cmd_pkg::ST_IDLE;
          end
        end
        epd_cmd_pkg::ST_LINE: begin
          next_line_period_count = pop_byte; // RULE9
          next_state = epd_cmd_pkg::ST_IDLE;
        end
        epd_cmd_pkg::ST_SEL: begin
          next_sensor_select_bit = pop_byte[epd_cmd_pkg::SEL_BIT_POS]; // RULE13
          next_temp_offset_field = pop_byte[3:0]; // RULE13
          next_state = epd_cmd_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    if (do_write) begin
      next_mem_we = 1'b1;
      next_mem_new_frame = (state == epd_cmd_pkg::ST_NEW);
      next_mem_x = pos_x;
      next_mem_y = pos_y;
      if (state == epd_cmd_pkg::ST_NEW) begin
        next_mem_colour = {quad_colour, 4'h0};
        next_mem_undef = {quad_undef, 4'h0};
        next_mem_mask = 8'hf0;
      end else begin
        next_mem_colour = pop_byte ^ {8{~data_polarity_bit}}; // RULE7 RULE8
        next_mem_undef = 8'h00;
        next_mem_mask = 8'hff;
      end
      // wrap to the window start once the row is full
      if (x_step >= x_end) begin
        next_pos_x = win_x;
        next_pos_y = pos_y + 10'h001;
      end else begin
        next_pos_x = x_step[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= epd_cmd_pkg::ST_IDLE;
      idx <= 3'h0;
      pos_x <= 8'h00;
      pos_y <= 10'h000;
      win_x <= 8'h00;
      win_y <= 10'h000;
      win_w <= 8'h00;
      win_l <= 10'h000;
      line_period_count <= epd_cmd_pkg::LINE_PERIOD_RST;
      sensor_select_bit <= epd_cmd_pkg::SENSOR_SEL_RST;
      temp_offset_field <= epd_cmd_pkg::TEMP_OFFSET_RST;
      mem_we <= 1'b0;
      mem_new_frame <= 1'b0;
      mem_x <= 8'h00;
      mem_y <= 10'h000;
      mem_colour <= 8'h00;
      mem_mask <= 8'h00;
      mem_undef <= 8'h00;
      rx_overflow <= 1'b0;
      req_tog <= 1'b0;
      resp_hold <= 16'h0000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      pos_x <= next_pos_x;
      pos_y <= next_pos_y;
      win_x <= next_win_x;
      win_y <= next_win_y;
      win_w <= next_win_w;
      win_l <= next_win_l;
      line_period_count <= next_line_period_count;
      sensor_select_bit <= next_sensor_select_bit;
      temp_offset_field <= next_temp_offset_field;
      mem_we <= next_mem_we;
      mem_new_frame <= next_mem_new_frame;
      mem_x <= next_mem_x;
      mem_y <= next_mem_y;
      mem_colour <= next_mem_colour;
      mem_mask <= next_mem_mask;
      mem_undef <= next_mem_undef;
      rx_overflow <= next_rx_overflow;
      req_tog <= next_req_tog;
      resp_hold <= next_resp_hold;
    end
  end

  // ****************************************
  // line period timer
  // ****************************************
  logic [epd_cmd_pkg::PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic [7:0] line_cnt, next_line_cnt;
  logic next_line_tick, ref_tick;

  assign ref_tick = (pre_cnt == epd_cmd_pkg::PRE_LAST);

  always_comb begin
    next_pre_cnt = ref_tick ? '0 : pre_cnt + 1'b1;
    next_line_cnt = line_cnt;
    next_line_tick = 1'b0;
    if (ref_tick) begin
      // >= keeps a shortened period from running past its end
      if (line_cnt >= line_period_count) begin // RULE10
        next_line_cnt = 8'h00;
        next_line_tick = 1'b1;
      end else begin
        next_line_cnt = line_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt <= '0;
      line_cnt <= 8'h00;
      line_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      line_cnt <= next_line_cnt;
      line_tick <= next_line_tick;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [8:0] gap;
  logic gap_ok;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 9'h000;
      gap_ok <= 1'b0;
    end else begin
      gap <= line_tick ? 9'h000 : gap + {8'h00, ref_tick};
      gap_ok <= line_tick ? 1'b1 : (gap_ok && $stable(line_period_count));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_param(epd_cmd_pkg::dec_state_t st);
    pop && pop_dc && state == st;
  endsequence
  sequence s_cmd(logic [7:0] code);
    pop && !pop_dc && pop_byte == code;
  endsequence

  a_cmd_enters_window: assert property (s_cmd(epd_cmd_pkg::CMD_WINDOW) |=> // RULE15
    state == epd_cmd_pkg::ST_WINDOW && idx == 3'h0) else $error("window command not taken");
  a_win_start_x: assert property (s_param(epd_cmd_pkg::ST_WINDOW) ##0 idx == 3'h0 |=> // RULE1
    win_x == $past(pop_byte)) else $error("window x not stored");
  a_win_len_end: assert property (s_param(epd_cmd_pkg::ST_WINDOW) ##0 idx == 3'h5 |=> // RULE2 RULE5
    win_l[7:0] == $past(pop_byte) && state == epd_cmd_pkg::ST_IDLE) else $error("window end");
  a_new_pixel_map: assert property (s_param(epd_cmd_pkg::ST_NEW) |=> mem_we && mem_new_frame && // RULE3 RULE4
    mem_colour[7] == ($past(data_polarity_bit) ? &$past(pop_byte[7:6]) : ~|$past(pop_byte[7:6])))
    else $error("2-bit pixel mapping wrong");
  a_mono_pixel_map: assert property (s_param(epd_cmd_pkg::ST_MONO) ##0 black_white_mode |=> // RULE7 RULE8
    mem_mask == 8'hff && mem_colour == ($past(pop_byte) ^ {8{~$past(data_polarity_bit)}}))
    else $error("1-bit pixel mapping wrong");
  a_line_store: assert property (s_param(epd_cmd_pkg::ST_LINE) |=> // RULE9
    line_period_count == $past(pop_byte) && state == epd_cmd_pkg::ST_IDLE) else $error("period");
  a_line_length: assert property (line_tick && gap_ok && $stable(line_period_count) |-> // RULE10
    gap == {1'b0, line_period_count} + 9'h001) else $error("line length not period plus one");
  a_sel_store: assert property (s_param(epd_cmd_pkg::ST_SEL) |=> // RULE13
    sensor_select_bit == $past(pop_byte[7]) && temp_offset_field == $past(pop_byte[3:0]))
    else $error("sensor select not stored");
  a_temp_internal: assert property (ack_s2 == req_tog && !sensor_select_bit |=> // RULE11 RULE14
    resp_hold[15:8] == $past(internal_temp_value) + {{3{$past(temp_offset_field[3])}},
    $past(temp_offset_field), 1'b0}) else $error("internal reading wrong");
  a_temp_external: assert property (ack_s2 == req_tog && sensor_select_bit |=> // RULE12
    resp_hold == {$past(ext_temp_value), 5'h00}) else $error("external reading wrong");
endmodule : epd_image_load_cmd_decoder
`default_nettype wire

// ==== epd_cmd_pkg.sv ====
// constants, states and the function list of the image-load command decoder
// assumes a host that sends command bytes with the select line low, data high
//
// Function
// RULE1: window start: 8-bit horizontal and 10-bit vertical coordinate from window bytes
// RULE2: window size: 8-bit width and 10-bit length, counted from the start
// RULE3: new-frame load bytes hold four 2-bit pixels, first pixel in top bits
// RULE4: polarity 1: code 00 black, 11 white; polarity 0 swaps; 01/10 undefined
// RULE5: window bytes: x, y high, y low, width, length high, length low
// RULE6: host keeps horizontal start and width multiples of four
// RULE7: both mono loads write eight 1-bit pixels MSB first, black/white mode only
// RULE8: mono pixel 0 black, 1 white at polarity 1; polarity 0 inverts
// RULE9: line period byte counts 1 MHz cycles; host keeps it at four or more
// RULE10: each line lasts programmed count plus one reference cycles
// RULE11: sensor select 0: first read byte is the internal sensor reading
// RULE12: sensor select 1: 11-bit external value, bits 10..3 then 2..0 on top
// RULE13: select byte: top bit picks sensor, low four bits hold temperature offset
// RULE14: internal reading is two's complement at half a degree per step
// RULE15: command byte with select low, parameters high, decoded by position
package epd_cmd_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_NEW_LOAD = 8'h13;
  localparam logic [7:0] CMD_WINDOW = 8'h14;
  localparam logic [7:0] CMD_MONO_OLD = 8'h15;
  localparam logic [7:0] CMD_MONO_SECOND = 8'h16;
  localparam logic [7:0] CMD_LINE_PERIOD = 8'h30;
  localparam logic [7:0] CMD_TEMP_READ = 8'h40;
  localparam logic [7:0] CMD_SENSOR_SEL = 8'h41;
  // ****************************************
  // positions, reset values, counts
  // ****************************************
  localparam logic [2:0] WIN_LAST_IDX = 3'h5;
  localparam int SEL_BIT_POS = 7;
  localparam logic [7:0] LINE_PERIOD_RST = 8'h12;
  localparam logic SENSOR_SEL_RST = 1'b0;
  localparam logic [3:0] TEMP_OFFSET_RST = 4'h0;
  localparam logic POLARITY_DEFAULT = 1'b1;
  localparam int CORE_PERIOD_NS = 10;
  localparam int REF_PERIOD_NS = 1000;
  localparam int REF_CYCLES = REF_PERIOD_NS / CORE_PERIOD_NS;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(REF_CYCLES - 1);
  localparam int LINK_WORD_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] QUAD_PIXELS = 4'h4;
  localparam logic [3:0] MONO_PIXELS = 4'h8;

  typedef enum {ST_IDLE, ST_WINDOW, ST_NEW, ST_MONO, ST_LINE, ST_SEL, ST_SKIP} dec_state_t;
endpackage : epd_cmd_pkg

// ==== byte_stream_if.sv ====
// valid/ready carrier for received link words between the decoder and its fifo
// assumes both ends on core_clk
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport sender(output valid, output data, input ready);
  modport receiver(input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ==== link_word_fifo.sv ====
// small synchronous fifo for received link words
// assumes one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module link_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // fill and drain sides
  byte_stream_if.receiver wr,
  byte_stream_if.sender rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign wr.ready = (count != FULL_COUNT);
  assign rd.valid = (count != '0);
  assign rd.data = mem[rd_ptr];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; words are only read once counted in
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  a_fifo_count_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    (count == FULL_COUNT) |-> ##1 (count >= FULL_COUNT - 1'b1))
    else $error("fifo count dropped by more than one");
endmodule : link_word_fifo
`default_nettype wire

// ==== epd_link_host.sv ====
// host side of the serial command link: clocks only inside a frame
// assumes the device samples mosi and dc on rising link_clk
`timescale 1ns/10ps
`default_nettype none
module epd_link_host (
  // link pins
  output logic link_clk,
  output logic link_cs_n,
  output logic link_dc,
  output logic link_mosi,
  input wire logic link_miso
);
  initial begin
    link_clk = 1'b0;
    link_cs_n = 1'b1;
    link_dc = 1'b0;
    link_mosi = 1'b0;
  end
  // one byte msb first, 6 ns bit; miso caught just before each rise
  task automatic xfer(input logic dc, input logic [7:0] tx, output logic [7:0] rx);
    link_cs_n = 1'b0;
    link_dc = dc;
    for (int i = 7; i >= 0; i--) begin
      link_mosi = tx[i];
      #3 rx[i] = link_miso;
      link_clk = 1'b1;
      #3 link_clk = 1'b0;
    end
  endtask : xfer
  task automatic end_frame;
    #3 link_cs_n = 1'b1;
  endtask : end_frame
endmodule : epd_link_host
`default_nettype wire

// ==== test_epd_image_load_cmd_decoder.sv ====
// self-checking bench of the image-load command decoder
// assumes the host model drives the link, bench drives core-side inputs
`timescale 1ns/10ps
`default_nettype none
module test_epd_image_load_cmd_decoder;
  logic core_clk, reset_n, link_clk, link_cs_n, link_dc, link_mosi, link_miso, link_miso_oe;
  logic data_polarity_bit, black_white_mode, mem_we, mem_new_frame, mem_ready, line_tick;
  logic sensor_select_bit, rx_ready, rx_overflow, clear_overflow, stall, mem_chk;
  logic [7:0] internal_temp_value, mem_x, mem_colour, mem_mask, mem_undef, win_x, win_w;
  logic [7:0] line_period_count, rx;
  logic [47:0] wbytes;
  logic [9:0] mem_y, win_y, win_l;
  logic [10:0] ext_temp_value;
  logic [3:0] temp_offset_field;
  logic [42:0] exq[$];
  logic [31:0] seed = 32'h00004e37;
  int miscompares, compares, n, wx, wy, ww, wl, ex, ey;
  epd_image_load_cmd_decoder dut_u (.*);
  epd_link_host host_u (.*);
  // ****************************************
  // clock, drivers, helpers
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  always @(negedge core_clk) mem_ready = stall ? 1'b0 : (rnd() > 8'h50);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  always @(posedge core_clk) begin
    if (mem_chk && mem_we === 1'b1 && mem_ready === 1'b1) begin
      if (exq.size() == 0) chk(64'h1, 64'h0);
      else chk({mem_new_frame, mem_x, mem_y, mem_colour & ~mem_undef, mem_mask, mem_undef},
               exq.pop_front());
    end
  end
  task automatic stop_test;
    $display("counts compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    #800000;
    miscompares++;
    stop_test();
  end
  task automatic cmd1(input logic [7:0] c, input logic [7:0] p);
    host_u.xfer(1'b0, c, rx);
    host_u.xfer(1'b1, p, rx);
    host_u.end_frame();
    repeat (12) @(posedge core_clk);
  endtask : cmd1
  task automatic tick_gap(output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (line_tick !== 1'b1 && k < 2500);
  endtask : tick_gap
  task automatic load(input logic [7:0] c, input logic pol);
    logic [7:0] b, col, u;
    logic [1:0] p;
    logic q;
    @(negedge core_clk) data_polarity_bit = pol;
    q = (c == epd_cmd_pkg::CMD_NEW_LOAD);
    ex = wx;
    ey = wy;
    host_u.xfer(1'b0, c, rx);
    for (int k = 0; k < 6; k++) begin
      b = rnd();
      u = 8'h00;
      col = b ~^ {8{pol}};
      for (int i = 0; q && i < 8; i++) begin
        p = b[7 - 2 * (i % 4) -: 2];
        u[7 - i] = (i < 4) && (p[1] ^ p[0]);
        col[7 - i] = (i < 4) && !u[7 - i] && ((p == 2'h3) ~^ pol);
      end
      exq.push_back({q, ex[7:0], ey[9:0], col, q ? 8'hf0 : 8'hff, u});
      host_u.xfer(1'b1, b, rx);
      ex += q ? 4 : 8;
      if (ex >= wx + ww) begin
        ex = wx;
        ey++;
      end
    end
    host_u.end_frame();
    for (int i = 0; i < 400 && exq.size() > 0; i++) @(posedge core_clk);
    chk(exq.size(), 0);
  endtask : load
  task automatic tread(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] m);
    // reading only crosses on link edges; an ignored command lets it catch up
    host_u.xfer(1'b0, 8'h00, rx);
    host_u.xfer(1'b0, epd_cmd_pkg::CMD_TEMP_READ, rx);
    repeat (10) @(posedge core_clk);
    host_u.xfer(1'b1, rnd(), rx);
    chk({link_miso_oe, rx}, {1'b1, hi});
    host_u.xfer(1'b1, rnd(), rx);
    chk(rx & m, lo);
    host_u.end_frame();
    chk(link_miso_oe, 1'b0);
    $display("test temp read done");
  endtask : tread
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset_n, clear_overflow, stall, mem_chk} = 4'h1;
    {data_polarity_bit, black_white_mode} = 2'h3;
    internal_temp_value = 8'hce;
    ext_temp_value = 11'h5a3;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    chk({line_period_count, win_x, win_w}, 24'h120000);
    tick_gap(n);
    tick_gap(n);
    chk(n, 1900);
    cmd1(epd_cmd_pkg::CMD_LINE_PERIOD, 8'h04);
    chk(line_period_count, 8'h04);
    tick_gap(n);
    tick_gap(n);
    tick_gap(n);
    chk(n, 500);
    $display("test line period done");
    wx = rnd() & 8'h7c;
    ww = 16;
    wy = {rnd(), rnd()} & 10'h3ff;
    wl = {rnd(), rnd()} & 10'h3ff;
    host_u.xfer(1'b0, epd_cmd_pkg::CMD_WINDOW, rx);
    wbytes = {wx[7:0], 6'h0, wy[9:8], wy[7:0], ww[7:0], 6'h0, wl[9:8], wl[7:0]};
    for (int i = 0; i < 6; i++) host_u.xfer(1'b1, wbytes[47 - 8 * i -: 8], rx);
    host_u.end_frame();
    repeat (12) @(posedge core_clk);
    chk({win_x, win_y, win_w, win_l}, {wx[7:0], wy[9:0], ww[7:0], wl[9:0]});
    for (int j = 0; j < 6; j++) begin
      load(j < 2 ? 8'h13 : (j < 4 ? 8'h15 : 8'h16), j[0]);
    end
    // mono data outside black/white mode must not reach memory
    @(negedge core_clk) black_white_mode = 1'b0;
    cmd1(epd_cmd_pkg::CMD_MONO_OLD, rnd());
    chk(mem_we, 1'b0);
    $display("test loads done");
    cmd1(epd_cmd_pkg::CMD_SENSOR_SEL, 8'h00);
    chk({sensor_select_bit, temp_offset_field}, 5'h00);
    tread(8'hce, 8'h00, 8'h00);
    cmd1(epd_cmd_pkg::CMD_SENSOR_SEL, 8'h85);
    chk({sensor_select_bit, temp_offset_field}, 5'h15);
    tread(8'hb4, 8'h60, 8'he0);
    stall = 1'b1;
    mem_chk = 1'b0;
    host_u.xfer(1'b0, epd_cmd_pkg::CMD_NEW_LOAD, rx);
    repeat (16) host_u.xfer(1'b1, rnd(), rx);
    host_u.end_frame();
    chk({rx_ready, rx_overflow}, 2'h1);
    // let the last byte cross and overflow before clearing
    repeat (8) @(posedge core_clk);
    stall = 1'b0;
    @(negedge core_clk) clear_overflow = 1'b1;
    @(negedge core_clk) clear_overflow = 1'b0;
    repeat (300) @(posedge core_clk);
    chk({rx_ready, rx_overflow}, 2'h2);
    $display("test overflow done");
    stop_test();
  end
endmodule : test_epd_image_load_cmd_decoder
`default_nettype wire
